/* File: design/fcs_bus_cycle.sv */
// one read or write cycle on the flash pins
// assumes the flash answers within the access time counted here
module fcs_bus_cycle (
  input  wire logic                      clk_in,
  input  wire logic                      rstn_in,
  input  wire logic                      start_in,
  input  wire logic                      write_in,
  input  wire logic [fcs_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [fcs_pkg::DATA_W-1:0] wdata_in,
  output logic                           done_out,
  output logic      [fcs_pkg::DATA_W-1:0] rdata_out,
  output logic      [fcs_pkg::ADDR_W-1:0] fl_addr_out,
  output logic                           fl_ce_n_out,
  output logic                           fl_we_n_out,
  output logic                           fl_oe_n_out,
  output logic      [fcs_pkg::DATA_W-1:0] fl_dq_out,
  output logic                           fl_dq_oe_out,
  input  wire logic [fcs_pkg::DATA_W-1:0] fl_dq_in
);
  typedef enum logic [3:0] {
    B_IDLE = 4'b0001,
    B_SET  = 4'b0010,
    B_ACT  = 4'b0100,
    B_REC  = 4'b1000
  } fcs_bst_t;

  localparam logic [fcs_pkg::CNT_W-1:0] SETUP_N = fcs_pkg::CNT_W'(fcs_pkg::SETUP_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] WP_N    = fcs_pkg::CNT_W'(fcs_pkg::WP_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] WPH_N   = fcs_pkg::CNT_W'(fcs_pkg::WPH_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] ACC_N   = fcs_pkg::CNT_W'(fcs_pkg::ACC_CYC);

  fcs_bst_t                    st_r;
  logic [fcs_pkg::CNT_W-1:0]   cnt_r;
  logic                        wr_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_r         <= B_IDLE;
      cnt_r        <= '0;
      wr_r         <= 1'b0;
      done_out     <= 1'b0;
      rdata_out    <= '0;
      fl_addr_out  <= '0;
      fl_ce_n_out  <= 1'b1;
      fl_we_n_out  <= 1'b1;
      fl_oe_n_out  <= 1'b1;
      fl_dq_out    <= '0;
      fl_dq_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (st_r)
        B_IDLE: begin
          if (start_in) begin
            wr_r         <= write_in;
            fl_addr_out  <= addr_in;
            fl_dq_out    <= wdata_in;
            fl_dq_oe_out <= write_in;
            fl_ce_n_out  <= 1'b0;
            cnt_r        <= SETUP_N;
            st_r         <= B_SET;
          end
        end
        B_SET: begin
          if (cnt_r <= 8'h01) begin
            // address is stable before the strobe falls
            fl_we_n_out <= ~wr_r;
            fl_oe_n_out <= wr_r;
            cnt_r       <= wr_r ? WP_N : ACC_N;
            st_r        <= B_ACT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        B_ACT: begin
          if (cnt_r <= 8'h01) begin
            // data stays driven past the rising strobe
            if (!wr_r) begin
              rdata_out <= fl_dq_in;
            end
            fl_we_n_out <= 1'b1;
            fl_oe_n_out <= 1'b1;
            cnt_r       <= WPH_N;
            st_r        <= B_REC;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        B_REC: begin
          fl_ce_n_out <= 1'b1;
          if (cnt_r <= 8'h01) begin
            fl_dq_oe_out <= 1'b0;
            done_out     <= 1'b1;
            st_r         <= B_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end
endmodule : fcs_bus_cycle

/* File: design/fcs_host.sv */
// host controller issuing flash command sequences and polling status
// assumes one flash device on the pins, ready/busy line pulled up outside
module fcs_host (
  input  wire logic                      clk_in,
  input  wire logic                      rstn_in,
  input  wire logic                      start_in,
  input  wire logic [3:0]                op_in,
  input  wire logic                      byte_mode_in,
  input  wire logic [fcs_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [fcs_pkg::DATA_W-1:0] data_in,
  output logic                           busy_out,
  output logic                           done_out,
  output logic                           fail_out,
  output logic      [fcs_pkg::DATA_W-1:0] result_out,
  output logic      [fcs_pkg::ADDR_W-1:0] fl_addr_out,
  output logic                           fl_ce_n_out,
  output logic                           fl_we_n_out,
  output logic                           fl_oe_n_out,
  output logic      [fcs_pkg::DATA_W-1:0] fl_dq_out,
  output logic                           fl_dq_oe_out,
  input  wire logic [fcs_pkg::DATA_W-1:0] fl_dq_in,
  input  wire logic                      ready_busy_in
);
  typedef enum logic [6:0] {
    S_IDLE   = 7'b000_0001,
    S_SEQ    = 7'b000_0010,
    S_SEQ_W  = 7'b000_0100,
    S_POLL   = 7'b000_1000,
    S_POLL_W = 7'b001_0000,
    S_FIN    = 7'b010_0000,
    S_FIN_W  = 7'b100_0000
  } fcs_st_t;

  fcs_st_t                     st_r;
  fcs_pkg::fcs_op_t            op_r;
  logic                        byte_r;
  logic [fcs_pkg::ADDR_W-1:0]  addr_r;
  logic [fcs_pkg::DATA_W-1:0]  data_r;
  logic [2:0]                  step_r;
  logic                        rechk_r;
  logic                        reset_after_r;
  logic                        bc_start;
  logic                        bc_done;
  logic [fcs_pkg::DATA_W-1:0]  bc_rdata;
  logic                        cy_last;
  logic                        cy_write;
  logic [fcs_pkg::ADDR_W-1:0]  cy_addr;
  logic [7:0]                  cy_data;
  logic [fcs_pkg::ADDR_W-1:0]  u1;
  logic [fcs_pkg::ADDR_W-1:0]  u2;
  logic                        needs_poll;
  logic                        exp_bit;

  ////////////////////////////////////////////////////////////////////////////
  // cycle table: unlock pair, command, then the op's own cycles; read, reset, suspend and resume are one cycle
  always_comb begin
    u1       = byte_r ? fcs_pkg::UNLOCK1_BYTE : fcs_pkg::UNLOCK1_WORD;
    u2       = byte_r ? fcs_pkg::UNLOCK2_BYTE : fcs_pkg::UNLOCK2_WORD;
    cy_write = 1'b1;
    cy_last  = 1'b0;
    cy_addr  = u1;
    cy_data  = fcs_pkg::UNLOCK_DATA1;
    if (step_r == 3'd1 || step_r == 3'd4) begin
      cy_addr = u2;
      cy_data = fcs_pkg::UNLOCK_DATA2;
    end
    unique case (op_r)
      fcs_pkg::FCS_OP_READ: begin
        cy_write = 1'b0;
        cy_addr  = addr_r;
        cy_last  = 1'b1;
      end
      fcs_pkg::FCS_OP_RESET: begin
        cy_addr = addr_r;
        cy_data = fcs_pkg::CMD_RESET;
        cy_last = 1'b1;
      end
      fcs_pkg::FCS_OP_SUSPEND: begin
        cy_addr = addr_r;
        cy_data = fcs_pkg::CMD_SUSPEND;
        cy_last = 1'b1;
      end
      fcs_pkg::FCS_OP_RESUME: begin
        cy_addr = addr_r;
        cy_data = fcs_pkg::CMD_RESUME;
        cy_last = 1'b1;
      end
      fcs_pkg::FCS_OP_PROGRAM: begin
        if (step_r == 3'd2) begin
          cy_data = fcs_pkg::CMD_PROGRAM;
        end else if (step_r == 3'd3) begin
          cy_addr = addr_r;
          cy_data = data_r[7:0];
          cy_last = 1'b1;
        end
      end
      fcs_pkg::FCS_OP_AUTOSEL: begin
        if (step_r == 3'd2) begin
          cy_data = fcs_pkg::CMD_AUTOSEL;
        end else if (step_r == 3'd3) begin
          cy_write = 1'b0; // offset read: id or protect state
          cy_addr  = addr_r;
        end else if (step_r >= 3'd4) begin
          cy_addr = addr_r;
          cy_data = fcs_pkg::CMD_RESET;
          cy_last = 1'b1;
        end
      end
      default: begin
        // chip or sector erase, six writes
        if (step_r == 3'd2) begin
          cy_data = fcs_pkg::CMD_ERASE;
        end else if (step_r >= 3'd5) begin
          cy_last = 1'b1;
          if (op_r == fcs_pkg::FCS_OP_SECTOR) begin
            cy_addr = addr_r;
            cy_data = fcs_pkg::CMD_SECTOR;
          end else begin
            cy_data = fcs_pkg::CMD_CHIP;
          end
        end
      end
    endcase
  end

  // programs and erases end in status polling
  assign needs_poll = (op_r == fcs_pkg::FCS_OP_PROGRAM) || (op_r == fcs_pkg::FCS_OP_CHIP) ||
                      (op_r == fcs_pkg::FCS_OP_SECTOR);
  // program expects the true bit, erase expects one
  assign exp_bit  = (op_r == fcs_pkg::FCS_OP_PROGRAM) ? data_r[fcs_pkg::POLL_BIT] : 1'b1;
  assign bc_start = (st_r == S_SEQ) || (st_r == S_POLL) ||
                    ((st_r == S_FIN) && ready_busy_in);
  assign busy_out = (st_r != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_r          <= S_IDLE;
      op_r          <= fcs_pkg::FCS_OP_READ;
      byte_r        <= 1'b0;
      addr_r        <= '0;
      data_r        <= '0;
      step_r        <= '0;
      rechk_r       <= 1'b0;
      reset_after_r <= 1'b0;
      done_out      <= 1'b0;
      fail_out      <= 1'b0;
      result_out    <= '0;
    end else begin
      done_out <= 1'b0;
      unique case (st_r)
        S_IDLE: begin
          if (start_in) begin
            op_r          <= fcs_pkg::fcs_op_t'(op_in);
            byte_r        <= byte_mode_in;
            addr_r        <= addr_in;
            data_r        <= data_in;
            step_r        <= '0;
            rechk_r       <= 1'b0;
            reset_after_r <= 1'b0;
            fail_out      <= 1'b0;
            st_r          <= S_SEQ;
          end
        end
        S_SEQ: begin
          st_r <= S_SEQ_W;
        end
        S_SEQ_W: begin
          if (bc_done) begin
            if (!cy_write) begin
              result_out <= bc_rdata;
            end
            step_r <= step_r + 3'd1;
            if (!cy_last) begin
              st_r <= S_SEQ;
            end else if (reset_after_r) begin
              done_out <= 1'b1;
              st_r     <= S_IDLE;
            end else if (needs_poll) begin
              st_r <= S_POLL;
            end else begin
              done_out <= 1'b1;
              st_r     <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          st_r <= S_POLL_W;
        end
        S_POLL_W: begin
          if (bc_done) begin
            if (bc_rdata[fcs_pkg::POLL_BIT] == exp_bit) begin
              st_r <= S_FIN;
            end else if (rechk_r) begin
              // fail confirmed: reset back to array reads
              fail_out      <= 1'b1;
              reset_after_r <= 1'b1;
              op_r          <= fcs_pkg::FCS_OP_RESET;
              st_r          <= S_SEQ;
            end else begin
              rechk_r <= bc_rdata[fcs_pkg::FAIL_BIT];
              st_r    <= S_POLL;
            end
          end
        end
        S_FIN: begin
          if (ready_busy_in) begin
            st_r <= S_FIN_W;
          end
        end
        S_FIN_W: begin
          if (bc_done) begin
            result_out <= bc_rdata;
            done_out   <= 1'b1;
            st_r       <= S_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // polls use the caller's address, inside the target sector
  fcs_bus_cycle u_cycle (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .start_in     (bc_start),
    .write_in     ((st_r == S_SEQ) && cy_write),
    .addr_in      ((st_r == S_SEQ) ? cy_addr : addr_r),
    .wdata_in     ({8'h00, cy_data}),
    .done_out     (bc_done),
    .rdata_out    (bc_rdata),
    .fl_addr_out  (fl_addr_out),
    .fl_ce_n_out  (fl_ce_n_out),
    .fl_we_n_out  (fl_we_n_out),
    .fl_oe_n_out  (fl_oe_n_out),
    .fl_dq_out    (fl_dq_out),
    .fl_dq_oe_out (fl_dq_oe_out),
    .fl_dq_in     (fl_dq_in)
  );
endmodule : fcs_host

/* File: shared/fcs_pkg.sv */
// constants for the flash command and status host controller
// assumes one 100 MHz clock and a flash device on plain parallel pins
// Overview of operation
// - unlock writes precede program, erase and autoselect commands
// - array read is one plain bus read
// - F0 write resets, leaves autoselect
// - host resets device after timeout fail
// - erase is six writes, 80 then 10/30
// - autoselect is 90 then read at offset
// - host polls at program or erasing-sector address
// - chip erase polled in non-protected sector; host polls at the caller's address
// - host takes final data from later read
// - host rechecks polling bit after timeout fail
package fcs_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam logic [16:0] UNLOCK1_WORD = 17'h0_5555;
  localparam logic [16:0] UNLOCK2_WORD = 17'h0_2AAA;
  localparam logic [16:0] UNLOCK1_BYTE = 17'h0_AAAA;
  localparam logic [16:0] UNLOCK2_BYTE = 17'h0_5555;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
  localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int FAIL_BIT    = 5;
  localparam int WINDOW_BIT  = 3;
  localparam int CLK_MHZ     = 100;
  localparam int T_SETUP_NS  = 10;
  localparam int T_WP_NS     = 35;
  localparam int T_WPH_NS    = 20;
  localparam int T_ACC_NS    = 70;
  localparam int SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC     = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W       = 8;

  typedef enum logic [3:0] {
    FCS_OP_READ    = 4'h0,
    FCS_OP_RESET   = 4'h1,
    FCS_OP_PROGRAM = 4'h2,
    FCS_OP_CHIP    = 4'h3,
    FCS_OP_SECTOR  = 4'h4,
    FCS_OP_AUTOSEL = 4'h5,
    FCS_OP_SUSPEND = 4'h6,
    FCS_OP_RESUME  = 4'h7
  } fcs_op_t;
endpackage : fcs_pkg

/* File: verif/fcs_flash_model.sv */
// flash device model: command decoder, status bits, ready/busy
// assumes host pins move on clk_in edges; sector 1 is protected
module fcs_flash_model #(
  parameter logic [7:0]  MFR  = 8'h3C,   // arbitrary code
  parameter logic [15:0] DEV  = 16'h5A3C, // arbitrary code
  parameter logic [3:0]  PSEC = 4'h1,
  parameter int PRG = 40, PPR = 200, ERS = 300, PER = 10000, WIN = 50
) (
  input  wire logic        clk_in,
  input  wire logic [16:0] addr_in,
  input  wire logic        ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [15:0] hdq_in,
  input  wire logic        hdq_oe_in,
  output logic      [15:0] dq_out,
  output logic             ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [256];
  logic [16:0] la = 0;
  logic [7:0]  pd = 0;
  logic [15:0] rv, lv = 0;
  logic        bm = 0, tog = 0, sect = 0;
  int          step = 0, md = 0, cnt = 0, win = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  task automatic cmd(input logic [15:0] a, input logic [7:0] d);
    logic [15:0] u1, u2;
    logic [7:0]  ix;
    u1 = bm ? 16'hAAAA : 16'h5555;
    u2 = bm ? 16'h5555 : 16'h2AAA;
    ix = {a[15:12], a[3:0]};
    if (md == 2 || md == 3) begin
      if (md == 3 && sect && d == 8'hB0) md = 5;
    end else if (d == 8'hF0) begin
      md = (md == 5) ? 5 : 0;
      step = 0;
    end else if (md == 5 && step == 0 && d == 8'h30) md = 3;
    else case (step)
      0: if (d == 8'hAA && (a == 16'h5555 || a == 16'hAAAA)) begin
        bm = a[15];
        step = 1;
      end
      1, 5: step = (d == 8'h55 && a == u2) ? step + 1 : 0;
      4: step = (d == 8'hAA && a == u1) ? 5 : 0;
      2: begin
        step = (a != u1) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
        if (a == u1 && d == 8'h90) md = 1;
      end
      3: begin
        step = 0;
        pd = d;
        md = 2;
        cnt = PRG;
        if (a[15:12] == PSEC) cnt = PPR;
        else if ((d & ~mem[ix]) != 0) md = 4;
        else mem[ix] = mem[ix] & d;
      end
      6: begin
        step = 0;
        sect = (d == 8'h30);
        win = sect ? WIN : 0;
        if (sect || (d == 8'h10 && a == u1)) begin
          md = 3;
          cnt = (sect && a[15:12] == PSEC) ? PER : ERS;
          foreach (mem[i]) if (i[7:4] != PSEC && (!sect || i[7:4] == a[15:12])) mem[i] = 8'hFF;
        end
      end
      default: step = 0;
    endcase
  endtask : cmd
  always @(negedge we_n_in) if (!ce_n_in) la = addr_in;
  always @(posedge we_n_in) if (!ce_n_in) cmd(la[15:0], hdq_in[7:0]);
  always @(posedge oe_n_in) begin
    lv = rv;
    if (md >= 2 && md <= 4) tog = ~tog;
  end
  // status moves on the falling edge so host samples never race it
  always @(negedge clk_in) begin
    if (win > 0) win = win - 1;
    else if (md == 2 || md == 3) cnt = cnt - 1;
    if (cnt <= 0 && (md == 2 || md == 3)) md = 0;
  end
  always_comb begin
    rv = {8'h00, mem[{addr_in[15:12], addr_in[3:0]}]};
    if (md == 2 || md == 4) rv = {8'h00, ~pd[7], tog, md == 4, 5'h00};
    if (md == 3) rv = {8'h00, 1'b0, tog, 2'h0, win <= 0, 3'h0};
    if (md == 1) begin
      rv = 16'h0000;
      if (addr_in[7:0] == 8'h00) rv = {8'h00, MFR};
      if (addr_in[7:0] == (bm ? 8'h02 : 8'h01)) rv = bm ? {8'h00, DEV[7:0]} : DEV;
      if (addr_in[7:0] == (bm ? 8'h04 : 8'h02)) rv = {15'h0, addr_in[15:12] == PSEC};
    end
  end
  assign dq_out = hdq_oe_in ? hdq_in : (!ce_n_in && !oe_n_in) ? rv : ~lv;
  assign ready_busy_out = !(md == 2 || md == 3 || md == 4);
endmodule : fcs_flash_model

/* File: verif/fcs_host_bench.sv */
// self-checking bench for fcs_host against the flash model
// assumes a 100 MHz clock and inputs driven on the falling edge
module fcs_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
    $display("Error %s exp %h got %h", n, e, s); end end
  localparam logic [7:0]  MFR = 8'h3C;   // arbitrary code
  localparam logic [15:0] DEV = 16'h5A3C; // arbitrary code
  logic clk_in = 0, rstn_in = 0, start_in = 0, byte_mode_in = 0, rb;
  logic [3:0]  op_in = 0;
  logic [16:0] addr_in = 0, fl_addr_out, a;
  logic [15:0] data_in = 0, result_out, fl_dq_out, dq;
  logic busy_out, done_out, fail_out, fl_ce_n_out, fl_we_n_out, fl_oe_n_out, fl_dq_oe_out;
  logic [7:0]  d;
  logic [17:0] q[$], n;
  int err_count = 0, tests_run = 0;
  fcs_host uut (.clk_in, .rstn_in, .start_in, .op_in, .byte_mode_in, .addr_in,
    .data_in, .busy_out, .done_out, .fail_out, .result_out, .fl_addr_out,
    .fl_ce_n_out, .fl_we_n_out, .fl_oe_n_out, .fl_dq_out, .fl_dq_oe_out,
    .fl_dq_in(dq), .ready_busy_in(rb));
  fcs_flash_model #(.MFR(MFR), .DEV(DEV)) u_flash (.clk_in, .addr_in(fl_addr_out),
    .ce_n_in(fl_ce_n_out), .we_n_in(fl_we_n_out), .oe_n_in(fl_oe_n_out),
    .hdq_in(fl_dq_out), .hdq_oe_in(fl_dq_oe_out), .dq_out(dq), .ready_busy_out(rb));
  initial forever #5 clk_in = ~clk_in;
  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic run(input logic [3:0] o, input logic b, input logic [16:0] ad,
                     input logic [15:0] dt, input logic c, f, input logic [15:0] r);
    @(negedge clk_in);
    op_in = o;
    byte_mode_in = b;
    addr_in = ad;
    data_in = dt;
    start_in = 1;
    q.push_back({c, f, r});
    @(negedge clk_in);
    start_in = 0;
    while (done_out !== 1'b1) @(negedge clk_in);
  endtask : run
  always @(negedge clk_in) if (done_out === 1'b1) begin
    n = (q.size() > 0) ? q.pop_front() : 18'h3_FFFF;
    `CHK("fail", n[16], fail_out)
    if (n[17]) `CHK("result", n[15:0], result_out)
  end
  initial begin
    #300_000;
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(69362));
    repeat (16) @(negedge clk_in);
    rstn_in = 1;
    a = {5'h02, 8'h00, 4'($urandom)};
    d = 8'($urandom) & 8'hFE;
    run(0, 0, a, 0, 1, 0, 16'h00FF);
    run(2, 0, a, {8'h00, d}, 1, 0, {8'h00, d});
    run(2, 1, a, 16'h0001, 0, 1, 0);
    run(0, 1, a, 0, 1, 0, {8'h00, d});
    run(2, 0, 17'h0_1005, 16'h0080, 1, 0, 16'h00FF);
    for (int b = 0; b < 2; b++) begin
      run(5, 1'(b), 0, 0, 1, 0, {8'h00, MFR});
      run(5, 1'(b), b ? 17'h0_0002 : 17'h0_0001, 0, 1, 0, b ? {8'h00, DEV[7:0]} : DEV);
      run(5, 1'(b), b ? 17'h0_1004 : 17'h0_1002, 0, 1, 0, 16'h0001);
      run(5, 1'(b), b ? 17'h0_2004 : 17'h0_2002, 0, 1, 0, 16'h0000);
    end
    run(1, 0, a, 0, 0, 0, 0);
    run(6, 1, a, 0, 0, 0, 0);
    run(7, 0, a, 0, 0, 0, 0);
    run(0, 0, a, 0, 1, 0, {8'h00, d});
    run(4, 0, a, 0, 1, 0, 16'h00FF);
    run(2, 1, 17'h0_3001, {8'h00, d}, 1, 0, {8'h00, d});
    run(3, 1, 17'h0_3001, 0, 1, 0, 16'h00FF);
    run(4, 1, 17'h0_1000, 0, 1, 0, 16'h00FF);
    end_of_test();
  end
endmodule : fcs_host_bench

/* File: verif/fcs_host_props.sv */
// checker on the fcs_host ports: strobe shape, hold and handshake
// assumes one clock domain, bound to fcs_host below
module fcs_host_props (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        start_in,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        fail_out,
  input wire logic [16:0] fl_addr_out,
  input wire logic        fl_ce_n_out,
  input wire logic        fl_we_n_out,
  input wire logic        fl_oe_n_out,
  input wire logic [15:0] fl_dq_out,
  input wire logic        fl_dq_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  property p_we_ce; !fl_we_n_out |-> !fl_ce_n_out; endproperty
  property p_we_oe; !fl_we_n_out |-> fl_oe_n_out && fl_dq_oe_out; endproperty
  property p_rd; !fl_oe_n_out |-> !fl_dq_oe_out && !fl_ce_n_out; endproperty
  property p_we_w; $fell(fl_we_n_out) |-> !fl_we_n_out [*4] ##1 fl_we_n_out; endproperty
  property p_hold; !fl_we_n_out |=> $stable(fl_addr_out) && $stable(fl_dq_out); endproperty
  property p_busy; start_in && !busy_out |=> busy_out; endproperty
  property p_done; done_out |=> !done_out; endproperty
  property p_fail; start_in && !busy_out |=> !fail_out; endproperty
  property p_idle; !busy_out |-> fl_we_n_out && fl_oe_n_out; endproperty
  a_we_ce: assert property (p_we_ce) else $error("we without ce");
  a_we_oe: assert property (p_we_oe) else $error("we with oe or no drive");
  a_rd: assert property (p_rd) else $error("read while driving");
  a_we_w: assert property (p_we_w) else $error("we pulse width");
  a_hold: assert property (p_hold) else $error("addr or data moved in write");
  a_busy: assert property (p_busy) else $error("start not taken");
  a_done: assert property (p_done) else $error("done too long");
  a_fail: assert property (p_fail) else $error("fail not cleared");
  a_idle: assert property (p_idle) else $error("strobe while idle");
  c_wr: cover property ($fell(fl_we_n_out));
  c_rd: cover property ($fell(fl_oe_n_out));
  c_fail: cover property ($rose(fail_out));
endmodule : fcs_host_props
bind fcs_host fcs_host_props u_props (.clk_in(clk_in), .rstn_in(rstn_in),
  .start_in(start_in), .busy_out(busy_out), .done_out(done_out),
  .fail_out(fail_out), .fl_addr_out(fl_addr_out), .fl_ce_n_out(fl_ce_n_out),
  .fl_we_n_out(fl_we_n_out), .fl_oe_n_out(fl_oe_n_out),
  .fl_dq_out(fl_dq_out), .fl_dq_oe_out(fl_dq_oe_out));
